/* File: fsu_pkg.sv */
package fsu_pkg;
  // register byte offsets
  localparam logic [7:0] ADR_CMD   = 8'h00;
  localparam logic [7:0] ADR_CFG   = 8'h04;
  localparam logic [7:0] ADR_MLO   = 8'h08;
  localparam logic [7:0] ADR_MHI   = 8'h0c;
  localparam logic [7:0] ADR_EA    = 8'h10;
  localparam logic [7:0] ADR_LIM   = 8'h14;
  localparam logic [7:0] ADR_SEG   = 8'h18;
  localparam logic [7:0] ADR_STAT  = 8'h1c;
  localparam logic [7:0] ADR_MASK  = 8'h20;
  localparam logic [7:0] ADR_FCODE = 8'h24;
  localparam logic [7:0] ADR_TOP   = 8'h28;
  localparam logic [7:0] ADR_SEL   = 8'h2c;
  localparam logic [7:0] ADR_SLO   = 8'h30;
  localparam logic [7:0] ADR_SMID  = 8'h34;
  localparam logic [7:0] ADR_SHI   = 8'h38;
  // first opcode bytes and modrm digits
  localparam logic [7:0] OP_D8    = 8'hd8;
  localparam logic [7:0] OP_DA    = 8'hda;
  localparam logic [7:0] OP_DC    = 8'hdc;
  localparam logic [7:0] OP_DE    = 8'hde;
  localparam logic [2:0] DIG_SUB  = 3'h4;
  localparam logic [2:0] DIG_REV  = 3'h5;
  // config fields
  localparam int CFG_RC  = 0;
  localparam int CFG_EMUL = 2;
  localparam int CFG_TSW  = 3;
  localparam int CFG_PM  = 4;
  localparam int CFG_ACE = 5;
  localparam int CFG_CPL = 6;
  localparam logic [1:0] CPL_USER = 2'h3;
  localparam logic [1:0] RC_NEAR  = 2'h0;
  localparam logic [1:0] RC_DOWN  = 2'h1;
  localparam logic [1:0] RC_UP    = 2'h2;
  // segment fields
  localparam int SEG_STK  = 0;
  localparam int SEG_NULL = 1;
  // status bits
  localparam int ST_DONE = 0;
  localparam int ST_INV  = 1;
  localparam int ST_DNA   = 2;
  localparam int ST_SS    = 3;
  localparam int ST_PROT  = 4;
  localparam int ST_PAGE  = 5;
  localparam int ST_ALIGN = 6;
  localparam int ST_BAD  = 7;
  // extended-real format constants
  localparam logic [14:0] EXP_MAX = 15'h7fff;
  localparam logic [14:0] SGL_ADJ = 15'h3f80;
  localparam logic [14:0] SGL_DEN = 15'h3f81;
  localparam logic [14:0] DBL_ADJ = 15'h3c00;
  localparam logic [14:0] DBL_DEN = 15'h3c01;
  localparam logic [14:0] INT_EXP = 15'h403e;
  localparam logic [79:0] QBIT    = 80'h0000_4000_0000_0000_0000;
  localparam logic [79:0] QNAN_IND = 80'hffff_c000_0000_0000_0000;
  localparam logic [63:0] INT_ONE = 64'h8000_0000_0000_0000;

  typedef enum logic [1:0] {
    FSU_F_SGL = 2'h0,
    FSU_F_DBL = 2'h1,
    FSU_F_I32 = 2'h2,
    FSU_F_I16 = 2'h3
  } fsu_fmt_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_EXEC = 4'h2,
    S_NORM = 4'h4,
    S_DONE = 4'h8
  } fsu_state_t;
endpackage

/* File: fsu_convert.sv */
`timescale 1ns/1ns
module fsu_convert (
  input  fsu_pkg::fsu_fmt_t fmt_in,
  input  logic [63:0]       raw_in,
  output logic [79:0]       ext_out
);
  import fsu_pkg::*;

  logic [63:0] mag;
  logic [6:0]  lz;
  logic        neg;

  // widen memory operand to extended real, integers exactly
  always_comb begin
    mag = 64'h0;
    lz = 7'h0;
    neg = 1'b0;
    ext_out = 80'h0;
    case (fmt_in)
      FSU_F_SGL: begin
        if (raw_in[30:23] == 8'hff)
          ext_out = {raw_in[31], EXP_MAX, 1'b1, raw_in[22:0], 40'h0};
        else if (raw_in[30:23] != 8'h0)
          ext_out = {raw_in[31], {7'h0, raw_in[30:23]} + SGL_ADJ, 1'b1, raw_in[22:0], 40'h0};
        else if (raw_in[22:0] != 23'h0)
          ext_out = {raw_in[31], SGL_DEN, 1'b0, raw_in[22:0], 40'h0};
        else
          ext_out = {raw_in[31], 79'h0};
      end
      FSU_F_DBL: begin
        if (raw_in[62:52] == 11'h7ff)
          ext_out = {raw_in[63], EXP_MAX, 1'b1, raw_in[51:0], 11'h0};
        else if (raw_in[62:52] != 11'h0)
          ext_out = {raw_in[63], {4'h0, raw_in[62:52]} + DBL_ADJ, 1'b1, raw_in[51:0], 11'h0};
        else if (raw_in[51:0] != 52'h0)
          ext_out = {raw_in[63], DBL_DEN, 1'b0, raw_in[51:0], 11'h0};
        else
          ext_out = {raw_in[63], 79'h0};
      end
      default: begin
        // integer zero comes out as plus zero
        if (fmt_in == FSU_F_I32)
          mag = {{32{raw_in[31]}}, raw_in[31:0]};
        else
          mag = {{48{raw_in[15]}}, raw_in[15:0]};
        neg = mag[63];
        if (neg)
          mag = -mag;
        for (int k = 0; k < 64; k++) begin
          if (mag[k])
            lz = 7'(63 - k);
        end
        if (mag != 64'h0)   // see [RULE_11]
          ext_out = {neg, INT_EXP - {8'h0, lz}, mag << lz};
      end
    endcase
  end
endmodule

/* File: fsu_subtract_unit.sv */
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
// Behaviour
// [RULE_01] memory real forms: stack top minus single or double real into stack top
// [RULE_02] memory integer forms: stack top minus 32 or 16 bit integer into top
// [RULE_03] integer source converts to extended real before subtracting
// [RULE_04] D8 register form: top minus reg i; DC form: reg i minus top
// [RULE_05] popping register form writes reg i minus top, then pops
// [RULE_06] operand-less form: register 1 minus top into register 1, always pops
// [RULE_07] pop marks top register empty and increments top pointer by one
// [RULE_08] destination is always a stack register; source register or memory
// [RULE_09] zero difference of like signs gives +0, -0 when rounding down
// [RULE_10] +0 minus -0 is +0; -0 minus +0 is -0, any rounding
// [RULE_11] integer zero source counts as plus zero
// [RULE_12] one infinity gives signed infinity; like-signed infinities raise invalid
// [RULE_13] emulation or task-switched bit set raises device-not-available, no execution
// [RULE_14] address beyond stack segment limit raises stack fault, code zero
// [RULE_15] address beyond code or data segment limit raises protection fault
// [RULE_16] page fault during operand access reported with its fault code; the code reports it only in protected mode
// [RULE_17] protected-mode unaligned access with checking faults only at privilege three
// [RULE_18] any not-a-number operand gives not-a-number result
// [RULE_19] nonzero minus zero returns dest; zero minus finite returns negated source
module fsu_subtract_unit (
  input  logic        core_clk_in,
  input  logic        reset_in,
  input  logic        wb_cyc_in,
  input  logic        wb_stb_in,
  input  logic        wb_we_in,
  input  logic [7:0]  wb_adr_in,
  input  logic [3:0]  wb_sel_in,
  input  logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic        wb_ack_out,
  input  logic        page_fault_in,
  input  logic [31:0] page_fault_code_in,
  output logic        irq_out
);
  import fsu_pkg::*;

  // all checks run on the core clock and rest during reset
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  typedef struct packed {
    fsu_state_t      st;
    logic            ack;
    logic [31:0]     dat;
    logic            irq;
    logic [15:0]     cmd;
    logic [8:0]      cfg;
    logic [31:0]     mlo;
    logic [31:0]     mhi;
    logic [31:0]     ea;
    logic [31:0]     lim;
    logic [1:0]      seg;
    logic [7:0]      stat;
    logic [7:0]      mask;
    logic [31:0]     fcode;
    logic [2:0]      top;
    logic [2:0]      sel;
    logic [7:0]      tag;
    logic [31:0]     slo;
    logic [31:0]     smid;
    logic [7:0][79:0] stk;
    logic [79:0]     opa;
    logic [79:0]     opb;
    logic [2:0]      dst;
    logic            pop;
    logic            spc;
    logic            rs;
    logic [15:0]     re;
    logic [67:0]     rm;
  } fsu_regs_t;

  fsu_regs_t   r;
  fsu_regs_t   n;
  logic        acc, wr, go, isreg, rev, okc, popc, pm, over;
  logic        gpf, ssf, pff, acf;
  logic [31:0] rd, wd, bm;
  logic [7:0]  opc, ev, clr;
  logic [2:0]  pi;
  logic [1:0]  rc, cpl;
  logic [3:0]  sz;
  logic [32:0] last;
  logic [79:0] cv, da, db, res;
  fsu_fmt_t    fmt;
  logic        as, sb, anan, bnan, ainf, binf, az, bz, spec, inv;
  logic        abig, add, stk_bit, rsg, inc;
  logic [14:0] aexp, bexp, ea1, eb1, xe;
  logic [63:0] am, bmn;
  logic [15:0] d, fe;
  logic [67:0] big, sml, sum;
  logic [64:0] mt;

  // memory operand widening
  fsu_convert fsu_convert_i (
    .fmt_in  (fmt),
    .raw_in  ({r.mhi, r.mlo}),
    .ext_out (cv)
  );

  // command decode and operand fault checks
  always_comb begin
    opc = wb_dat_in[7:0];
    isreg = wb_dat_in[15:14] == 2'b11;
    pi = r.top + wb_dat_in[10:8];
    rc = r.cfg[CFG_RC+:2];
    cpl = r.cfg[CFG_CPL+:2];
    pm = r.cfg[CFG_PM];
    case (opc)
      OP_D8:   fmt = FSU_F_SGL;   // see [RULE_01]
      OP_DC:   fmt = FSU_F_DBL;   // see [RULE_01]
      OP_DA:   fmt = FSU_F_I32;   // see [RULE_02]
      default: fmt = FSU_F_I16;   // see [RULE_02]
    endcase
    case (fmt)
      FSU_F_DBL: sz = 4'h8;
      FSU_F_I16: sz = 4'h2;
      default:   sz = 4'h4;
    endcase
    // see [RULE_08]
    if (isreg)
      okc = (opc == OP_D8 && wb_dat_in[13:11] == DIG_SUB) ||
            ((opc == OP_DC || opc == OP_DE) && wb_dat_in[13:11] == DIG_REV);
    else
      okc = wb_dat_in[13:11] == DIG_SUB &&
            (opc == OP_D8 || opc == OP_DC || opc == OP_DA || opc == OP_DE);
    rev = isreg && opc != OP_D8;         // see [RULE_04]
    popc = isreg && opc == OP_DE;        // see [RULE_05] see [RULE_06]
    da = rev ? r.stk[pi] : r.stk[r.top];
    db = !isreg ? cv : (rev ? r.stk[r.top] : r.stk[pi]);   // see [RULE_03]
    last = {1'b0, r.ea} + {29'h0, sz - 4'h1};
    over = last > {1'b0, r.lim};
    gpf = (over && !r.seg[SEG_STK]) || (pm && r.seg[SEG_NULL]);   // see [RULE_15]
    ssf = over && r.seg[SEG_STK];                                 // see [RULE_14]
    pff = pm && page_fault_in;                                    // see [RULE_16]
    acf = pm && r.cfg[CFG_ACE] && cpl == CPL_USER &&
          (r.ea[3:0] & (sz - 4'h1)) != 4'h0;                      // see [RULE_17]
  end

  // operand classes, aligned difference, special results, rounding
  always_comb begin
    as = r.opa[79];
    sb = ~r.opb[79];
    aexp = r.opa[78:64];
    bexp = r.opb[78:64];
    am = r.opa[63:0];
    bmn = r.opb[63:0];
    anan = aexp == EXP_MAX && am[62:0] != 63'h0;
    bnan = bexp == EXP_MAX && bmn[62:0] != 63'h0;
    ainf = aexp == EXP_MAX && !anan;
    binf = bexp == EXP_MAX && !bnan;
    az = am == 64'h0 && aexp != EXP_MAX;
    bz = bmn == 64'h0 && bexp != EXP_MAX;
    spec = anan | bnan | ainf | binf | az | bz;
    ea1 = (aexp == 15'h0) ? 15'h1 : aexp;
    eb1 = (bexp == 15'h0) ? 15'h1 : bexp;
    abig = ea1 > eb1 || (ea1 == eb1 && am >= bmn);
    xe = abig ? ea1 : eb1;
    big = {1'b0, abig ? am : bmn, 3'h0};
    sml = {1'b0, abig ? bmn : am, 3'h0};
    d = {1'b0, abig ? ea1 - eb1 : eb1 - ea1};
    // shifted-out bits fold into a sticky lsb
    if (d > 16'h42) begin
      stk_bit = |sml;
      sml = 68'h0;
    end else begin
      stk_bit = |(sml & ~({68{1'b1}} << d));
      sml = sml >> d;
    end
    sml = sml | {67'h0, stk_bit};
    add = as == sb;
    sum = add ? big + sml : big - sml;
    rsg = add ? as : (abig ? as : sb);
    inv = 1'b0;
    if (anan | bnan) begin
      res = anan ? (r.opa | QBIT) : (r.opb | QBIT);                // see [RULE_18]
      inv = (anan && !am[62]) || (bnan && !bmn[62]);
    end else if (ainf && binf && as == r.opb[79]) begin
      res = QNAN_IND;                                              // see [RULE_12]
      inv = 1'b1;
    end else if (ainf)
      res = r.opa;                                                 // see [RULE_12]
    else if (binf)
      res = {sb, r.opb[78:0]};
    else if (az && bz)
      res = {(as == sb) ? as : (rc == RC_DOWN), 79'h0};            // see [RULE_10]
    else if (bz)
      res = r.opa;                                                 // see [RULE_19]
    else
      res = {sb, r.opb[78:0]};                                     // see [RULE_19]
    // guard bits decide the increment per rounding mode
    case (rc)
      RC_NEAR: inc = r.rm[2] && (r.rm[1] | r.rm[0] | r.rm[3]);
      RC_UP:   inc = !r.rs && r.rm[2:0] != 3'h0;
      RC_DOWN: inc = r.rs && r.rm[2:0] != 3'h0;
      default: inc = 1'b0;
    endcase
    mt = {1'b0, r.rm[66:3]} + {64'h0, inc};
    fe = r.re + {15'h0, mt[64]};
    if (mt[64])
      mt[63:0] = INT_ONE;
  end

  // bus slave, register file, sequencer
  always_comb begin
    n = r;
    ev = 8'h0;
    bm = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    acc = wb_cyc_in && wb_stb_in && !r.ack;
    wr = wb_cyc_in && wb_stb_in && wb_we_in && r.ack;
    go = wr && wb_adr_in == ADR_CMD && r.st == S_IDLE;
    case (wb_adr_in)
      ADR_CMD:   rd = {16'h0, r.cmd};
      ADR_CFG:   rd = {23'h0, r.cfg};
      ADR_MLO:   rd = r.mlo;
      ADR_MHI:   rd = r.mhi;
      ADR_EA:    rd = r.ea;
      ADR_LIM:   rd = r.lim;
      ADR_SEG:   rd = {30'h0, r.seg};
      ADR_STAT:  rd = {23'h0, r.st != S_IDLE, r.stat};
      ADR_MASK:  rd = {24'h0, r.mask};
      ADR_FCODE: rd = r.fcode;
      ADR_TOP:   rd = {16'h0, r.tag, 5'h0, r.top};
      ADR_SEL:   rd = {29'h0, r.sel};
      ADR_SLO:   rd = r.stk[r.sel][31:0];
      ADR_SMID:  rd = r.stk[r.sel][63:32];
      ADR_SHI:   rd = {16'h0, r.stk[r.sel][79:64]};
      default:   rd = 32'h0;
    endcase
    wd = (rd & ~bm) | (wb_dat_in & bm);
    clr = (wr && wb_adr_in == ADR_STAT) ? (wb_dat_in[7:0] & bm[7:0]) : 8'h0;
    n.ack = acc;
    if (acc)
      n.dat = rd;
    if (wr) begin
      case (wb_adr_in)
        ADR_CFG:  n.cfg = wd[8:0];
        ADR_MLO:  n.mlo = wd;
        ADR_MHI:  n.mhi = wd;
        ADR_EA:   n.ea = wd;
        ADR_LIM:  n.lim = wd;
        ADR_SEG:  n.seg = wd[1:0];
        ADR_MASK: n.mask = wd[7:0];
        ADR_TOP: begin
          n.top = wd[2:0];
          n.tag = wd[15:8];
        end
        ADR_SEL:  n.sel = wd[2:0];
        ADR_SLO:  n.slo = wd;
        ADR_SMID: n.smid = wd;
        ADR_SHI: begin
          n.stk[r.sel] = {wd[15:0], r.smid, r.slo};
          n.tag[r.sel] = 1'b1;
        end
        default: ;
      endcase
    end
    case (r.st)
      S_IDLE: begin
        if (go) begin
          n.cmd = wb_dat_in[15:0];
          n.fcode = 32'h0;
          if (r.cfg[CFG_EMUL] || r.cfg[CFG_TSW])
            ev[ST_DNA] = 1'b1;                                 // see [RULE_13]
          else if (!okc)
            ev[ST_BAD] = 1'b1;
          else if (!isreg && gpf)
            ev[ST_PROT] = 1'b1;                                // see [RULE_15]
          else if (!isreg && ssf)
            ev[ST_SS] = 1'b1;                                  // see [RULE_14]
          else if (!isreg && pff) begin
            ev[ST_PAGE] = 1'b1;                                // see [RULE_16]
            n.fcode = page_fault_code_in;
          end else if (!isreg && acf)
            ev[ST_ALIGN] = 1'b1;                               // see [RULE_17]
          else if (!r.tag[r.top] || (isreg && !r.tag[pi])) begin
            ev[ST_INV] = 1'b1;
            ev[ST_DONE] = 1'b1;
          end else begin
            n.opa = da;
            n.opb = db;
            n.dst = rev ? pi : r.top;                          // see [RULE_04] see [RULE_05]
            n.pop = popc;                                      // see [RULE_06]
            n.st = S_EXEC;
          end
        end
      end
      S_EXEC: begin
        n.spc = spec;
        n.st = S_DONE;
        if (spec) begin
          n.rs = res[79];
          n.re = {1'b0, res[78:64]};
          n.rm = {1'b0, res[63:0], 3'h0};
          ev[ST_INV] = inv;                                    // see [RULE_12]
        end else if (sum == 68'h0) begin
          n.rs = rc == RC_DOWN;                                // see [RULE_09]
          n.re = 16'h0;
          n.rm = 68'h0;
        end else if (sum[67]) begin
          n.rs = rsg;
          n.re = {1'b0, xe} + 16'h1;
          n.rm = {1'b0, sum[67:2], sum[1] | sum[0]};
        end else begin
          n.rs = rsg;
          n.re = {1'b0, xe};
          n.rm = sum;
          n.st = S_NORM;
        end
      end
      S_NORM: begin
        // one bit per cycle, stopping at the denormal floor
        if (r.rm[66] || r.re <= 16'h1)
          n.st = S_DONE;
        else begin
          n.rm = r.rm << 1;
          n.re = r.re - 16'h1;
        end
      end
      S_DONE: begin
        if (!r.spc && fe >= {1'b0, EXP_MAX})
          n.stk[r.dst] = {r.rs, EXP_MAX, INT_ONE};
        else
          n.stk[r.dst] = {r.rs, mt[63] ? fe[14:0] : 15'h0, mt[63:0]};   // see [RULE_08]
        n.tag[r.dst] = 1'b1;
        if (r.pop) begin
          n.tag[r.top] = 1'b0;                                 // see [RULE_07]
          n.top = r.top + 3'h1;                                // see [RULE_07]
        end
        ev[ST_DONE] = 1'b1;
        n.st = S_IDLE;
      end
      default: n.st = S_IDLE;
    endcase
    // sticky status, a new event beats a same-cycle clear
    n.stat = (r.stat & ~clr) | ev;
    n.irq = (n.stat & n.mask) != 8'h0;
  end

  // state register
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      r <= '0;
      r.st <= S_IDLE;
    end else begin
      r <= n;
    end
  end

  assign wb_ack_out = r.ack;
  assign wb_dat_out = r.dat;
  assign irq_out = r.irq;

  property p_ack;
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack not one cycle after request");

  property p_nm;
    go && (r.cfg[CFG_EMUL] || r.cfg[CFG_TSW]) |=>
      r.stat[ST_DNA] && r.st == S_IDLE && r.top == $past(r.top);
  endproperty
  a_nm: assert property (p_nm) else $error("device-not-available not raised"); // see [RULE_13]

  property p_pop;
    r.st == S_DONE && r.pop |=> r.top == $past(r.top) + 3'h1 && !r.tag[$past(r.top)];
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not empty and advance top"); // see [RULE_07]

  property p_zero;
    r.st == S_EXEC && !spec && sum == 68'h0 |=>
      r.rs == ($past(rc) == RC_DOWN) && r.rm == 68'h0 ##1 r.st == S_IDLE;
  endproperty
  a_zero: assert property (p_zero) else $error("zero difference sign wrong"); // see [RULE_09]

  property p_inf;
    r.st == S_EXEC && ainf && binf && r.opa[79] == r.opb[79] |=> r.stat[ST_INV];
  endproperty
  a_inf: assert property (p_inf) else $error("like infinities not invalid"); // see [RULE_12]

  property p_nan;
    r.st == S_EXEC && (anan || bnan) |=> r.re[14:0] == EXP_MAX && r.rm[65:3] != 63'h0;
  endproperty
  a_nan: assert property (p_nan) else $error("nan operand lost"); // see [RULE_18]

  property p_rz;
    r.st == S_EXEC && !anan && !ainf && !az && bz |=> r.rm[66:3] == $past(am);
  endproperty
  a_rz: assert property (p_rz) else $error("dest minus zero altered"); // see [RULE_19]

  property p_ss;
    $rose(r.stat[ST_SS]) |-> r.fcode == 32'h0;
  endproperty
  a_ss: assert property (p_ss) else $error("stack fault code not zero"); // see [RULE_14]

  property p_ac;
    $rose(r.stat[ST_ALIGN]) |-> $past(cpl) == CPL_USER && $past(pm);
  endproperty
  a_ac: assert property (p_ac) else $error("alignment fault outside privilege three"); // see [RULE_17]
endmodule

/* File: fsu_pager_model.sv */
`timescale 1ns/1ns
module fsu_pager_model (
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic        fault_req_in,
  input  wire logic [31:0] code_in,
  output logic             page_fault_out,
  output logic [31:0]      fault_code_out
);
  logic [31:0] junk;

  // code lines toggle when no fault is reported
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      junk <= 32'h0;
    end else begin
      junk <= ~junk;
    end
  end

  // fault level and code from the paging side
  assign page_fault_out = fault_req_in;
  assign fault_code_out = fault_req_in ? code_in : junk;
endmodule

/* File: fsu_subtract_unit_test.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module fsu_subtract_unit_test;
  import fsu_pkg::*;
  localparam logic [79:0] E1 = 80'h3fff_8000_0000_0000_0000;
  localparam logic [79:0] E2 = 80'h4000_8000_0000_0000_0000;
  localparam logic [79:0] E3 = 80'h4000_c000_0000_0000_0000;
  localparam logic [79:0] N1 = 80'hbfff_8000_0000_0000_0000;
  localparam logic [79:0] PI = 80'h7fff_8000_0000_0000_0000;
  localparam logic [79:0] NZ = 80'h8000_0000_0000_0000_0000;
  localparam logic [79:0] QN = 80'h7fff_c000_0000_0000_0000;
  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic        pg_req   = 1'b0;
  logic [3:0]  sel      = 4'h0;
  logic [7:0]  adr      = 8'h0;
  logic [31:0] wdat     = 32'h0;
  logic [31:0] pcode    = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic        ack;
  logic        irq;
  logic        pg_flt;
  logic [31:0] pg_code;
  logic [2:0]  top      = 3'h0;
  logic [7:0]  msk      = 8'h0;
  int          fail_count = 0;
  int          tests_run  = 0;

  fsu_subtract_unit fsu_subtract_unit_i (
    .core_clk_in(core_clk), .reset_in(reset), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .page_fault_in(pg_flt),
    .page_fault_code_in(pg_code), .irq_out(irq));

  fsu_pager_model fsu_pager_model_i (
    .core_clk_in(core_clk), .reset_in(reset), .fault_req_in(pg_req),
    .code_in(pcode), .page_fault_out(pg_flt), .fault_code_out(pg_code));

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  // one classic cycle, held until ack is sampled; only the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    sel <= 4'hf;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge core_clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask

  // stack entry access by physical index
  task automatic load(input logic [2:0] p, input logic [79:0] v);
    wb(1'b1, ADR_SEL, {29'h0, p});
    wb(1'b1, ADR_SLO, v[31:0]);
    wb(1'b1, ADR_SMID, v[63:32]);
    wb(1'b1, ADR_SHI, {16'h0, v[79:64]});
  endtask

  task automatic env(input logic [7:0] c, input logic [31:0] ea, lim, input logic s, p);
    wb(1'b1, ADR_CFG, {24'h0, c});
    wb(1'b1, ADR_EA, ea);
    wb(1'b1, ADR_LIM, lim);
    wb(1'b1, ADR_SEG, {31'h0, s});
    pg_req <= p;
    pcode <= 32'h0000_0007;
  endtask

  // one command: load operands, run, check status, irq, result and top
  task automatic tc(input logic [7:0] op, rm, input logic [63:0] m,
                    input logic [79:0] a0, ai, input int i, di, input logic pop,
                    input logic [79:0] e, input logic [7:0] s);
    logic [2:0]  dp;
    logic [2:0]  ot;
    logic [79:0] v;
    int          n;
    dp = top + di[2:0];
    ot = top;
    load(top, a0);
    if (i != 0) load(top + i[2:0], ai);
    wb(1'b1, ADR_MLO, m[31:0]);
    wb(1'b1, ADR_MHI, m[63:32]);
    wb(1'b1, ADR_CMD, {16'h0, rm, op});
    n = 0;
    do begin
      wb(1'b0, ADR_STAT, 32'h0);
      n++;
    end while ((rd[8] !== 1'b0 || rd[7:0] === 8'h0) && n < 100);
    if (n >= 100) begin
      fail_count++;
      conclude();
    end
    `CHK("status", s, rd[7:0])
    `CHK("irq", |(s & msk), irq)
    wb(1'b1, ADR_STAT, 32'hff);
    if (pop) top = top + 3'h1;
    wb(1'b1, ADR_SEL, {29'h0, dp});
    wb(1'b0, ADR_SLO, 32'h0);
    v[31:0] = rd;
    wb(1'b0, ADR_SMID, 32'h0);
    v[63:32] = rd;
    wb(1'b0, ADR_SHI, 32'h0);
    v[79:64] = rd[15:0];
    `CHK("result", e, v)
    wb(1'b0, ADR_TOP, 32'h0);
    `CHK("top", top, rd[2:0])
    if (pop) `CHK("tag", 1'b0, rd[8 + ot])
    `CHK("irq clear", 1'b0, irq)
  endtask

  task automatic m1(input logic [7:0] op, input logic [63:0] m, input logic [79:0] a, e,
                    input logic [7:0] s);
    tc(op, 8'h20, m, a, 80'h0, 0, 0, 1'b0, e, s);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #400000;
    fail_count++;
    conclude();
  end

  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    wb(1'b1, 8'h3c, 32'h5a5a_5a5a);
    rchk("unmapped", 8'h3c, 32'h0);
    rchk("stat rst", ADR_STAT, 32'h0);
    rchk("top rst", ADR_TOP, 32'h0);
    rchk("cfg rst", ADR_CFG, 32'h0);
    env(8'h0, 32'h0, 32'hffff_ffff, 1'b0, 1'b0);
    msk = 8'h01;
    wb(1'b1, ADR_MASK, 32'h1);
    m1(OP_D8, 64'h3f80_0000, E3, E2, 8'h01);
    m1(OP_DC, 64'h3ff0_0000_0000_0000, E2, E1, 8'h01);
    m1(OP_DA, 64'h1, E3, E2, 8'h01);
    m1(OP_DE, 64'hffff_0002, E3, E1, 8'h01);
    tc(OP_D8, 8'he1, 64'h0, E3, E1, 1, 0, 1'b0, E2, 8'h01);
    tc(OP_DC, 8'he9, 64'h0, E1, E3, 1, 1, 1'b0, E2, 8'h01);
    tc(OP_DE, 8'he9, 64'h0, E1, E3, 1, 1, 1'b1, E2, 8'h01);
    tc(OP_DE, 8'hea, 64'h0, E1, E3, 2, 2, 1'b1, E2, 8'h01);
    msk = 8'h0;
    wb(1'b1, ADR_MASK, 32'h0);
    m1(OP_D8, 64'h3f80_0000, E1, 80'h0, 8'h01);
    wb(1'b1, ADR_CFG, {30'h0, RC_DOWN});
    m1(OP_D8, 64'h3f80_0000, E1, NZ, 8'h01);
    m1(OP_D8, 64'h8000_0000, 80'h0, 80'h0, 8'h01);
    wb(1'b1, ADR_CFG, {30'h0, RC_NEAR});
    m1(OP_D8, 64'h0, NZ, NZ, 8'h01);
    m1(OP_DA, 64'h0, NZ, NZ, 8'h01);
    m1(OP_D8, 64'h3f80_0000, PI, PI, 8'h01);
    m1(OP_D8, 64'h7f80_0000, PI, QNAN_IND, 8'h03);
    m1(OP_D8, 64'h7fc0_0000, E1, QN, 8'h01);
    m1(OP_D8, 64'h0, E2, E2, 8'h01);
    m1(OP_D8, 64'h3f80_0000, 80'h0, N1, 8'h01);
    msk = 8'h7e;
    wb(1'b1, ADR_MASK, 32'h7e);
    env(8'h04, 32'h0, 32'hffff_ffff, 1'b0, 1'b0);
    m1(OP_D8, 64'h3f80_0000, E3, E3, 8'h04);
    env(8'h08, 32'h0, 32'hffff_ffff, 1'b0, 1'b0);
    m1(OP_DC, 64'h3ff0_0000_0000_0000, E3, E3, 8'h04);
    env(8'h00, 32'h20, 32'h10, 1'b0, 1'b0);
    m1(OP_D8, 64'h3f80_0000, E3, E3, 8'h10);
    env(8'h00, 32'h20, 32'h10, 1'b1, 1'b0);
    m1(OP_DA, 64'h1, E3, E3, 8'h08);
    rchk("fcode", ADR_FCODE, 32'h0);
    env(8'h10, 32'h0, 32'hffff_ffff, 1'b0, 1'b1);
    m1(OP_D8, 64'h3f80_0000, E3, E3, 8'h20);
    rchk("fcode", ADR_FCODE, 32'h0000_0007);
    env(8'hf0, 32'h2, 32'hffff_ffff, 1'b0, 1'b0);
    m1(OP_D8, 64'h3f80_0000, E3, E3, 8'h40);
    env(8'h30, 32'h2, 32'hffff_ffff, 1'b0, 1'b0);
    m1(OP_D8, 64'h3f80_0000, E3, E2, 8'h01);
    conclude();
  end
endmodule
